// [design/mcd_decoder.sv]
// Purpose: mode code / subaddress decode and mode code handling
// Assumes: commands arrive already validated, one at a time
// Notes:   illegal-command input is sampled one cycle after
//          the command is taken, while the field pins are valid
`timescale 1ns/100ps
`include "mcd_params.svh"
module mcd_decoder
	import mcd_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        cmd_valid_in,
	input  wire logic [15:0] cmd_word_in,
	input  wire logic        broadcast_indicator_in,
	input  wire logic        cmd_on_a_in,
	input  wire logic        illegal_command_input_in,
	input  wire logic        data_valid_in,
	input  wire logic [15:0] data_word_in,
	input  wire logic [4:0]  rt_addr_in,
	input  wire logic        tx_ready_in,
	output logic [4:0]       field_value_pins_out,
	output logic             field_type_indicator_out,
	output logic             message_error_pin_out,
	output logic             tx_valid_out,
	output logic [15:0]      tx_word_out,
	output logic             chan_a_en_out,
	output logic             chan_b_en_out,
	output logic             sync_req_out,
	output logic             self_test_req_out,
	output logic             reset_req_out,
	output logic             msg_accept_out,
	output logic             irq_out,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic [31:0]      hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out
);
	mcd_state_e  st_q;
	mcd_extra_e  xsel_q;
	mcd_cmd_s    cmd_q;
	mcd_cmd_s    cmd_in;
	mcd_field_s  fld_q;
	logic [15:0] last_cmd_q;
	logic [15:0] sync_data_q;
	logic [15:0] vec_q;
	logic [15:0] bit_q;
	logic [15:0] tx_word_q;
	logic [15:0] extra_word;
	logic [15:0] status_word;
	logic [15:0] status_reg;
	logic [2:0]  ctl_q;
	logic [4:0]  irq_mask_q;
	logic [4:0]  irq_stat;
	logic [4:0]  irq_ev;
	logic [0:0]  message_error_pin_stk;
	logic        message_error_pin_q;
	logic        me_q;
	logic        me_src;
	logic        tf_en_q;
	logic        cha_q;
	logic        chb_q;
	logic        cmd_a_q;
	logic        bcast_q;
	logic        sync_q;
	logic        stest_q;
	logic        rstreq_q;
	logic        accept_q;
	logic        mode_cmd;
	logic        mc_bad;
	logic        sa_bad;
	logic        ill_now;
	logic        chk;
	logic        chk_ok;
	logic        keep_sw;
	logic        is_tlc;
	logic        inh_now;
	logic        wdata_go;
	logic        stat_go;
	logic        wr_q;
	logic        rd_q;
	logic [7:0]  addr_q;
	logic [31:0] rdata;

	// ****************************************
	// command decode
	// ****************************************
	assign cmd_in   = mcd_cmd_s'(cmd_word_in);
	assign mode_cmd = (cmd_q.sa == `MCD_SA_MC0) ||
		(cmd_q.sa == `MCD_SA_MC31);
	assign chk      = (st_q == ST_CHECK);

	// only the listed codes are legal; reserved and undefined fall out
	always_comb begin
		unique case ({cmd_q.tx, cmd_q.wc})
			{1'b1, `MCD_MC_SYNC},
			{1'b1, `MCD_MC_TXSTAT},
			{1'b1, `MCD_MC_STEST},
			{1'b1, `MCD_MC_TXSHUT},
			{1'b1, `MCD_MC_OVRSHUT},
			{1'b1, `MCD_MC_INHTF},
			{1'b1, `MCD_MC_OVRTF},
			{1'b1, `MCD_MC_RSTRT},
			{1'b1, `MCD_MC_TXVEC},
			{1'b1, `MCD_MC_TXLAST},
			{1'b1, `MCD_MC_TXBIT},
			{1'b0, `MCD_MC_SYNCD}: mc_bad = 1'b0;
			default: mc_bad = 1'b1;
		endcase
	end

	mcd_sa_table u_sa (
		.notice3_in  (ctl_q[`MCD_CTL_NOTICE3]),
		.rx_in       (!cmd_q.tx),
		.sa_in       (cmd_q.sa),
		.illegal_out (sa_bad)
	);

	// host veto joins the internal decode
	assign ill_now  = illegal_command_input_in |
		(mode_cmd ? mc_bad : sa_bad);
	assign chk_ok   = chk && !ill_now && mode_cmd;
	assign is_tlc   = mode_cmd && cmd_q.tx && cmd_q.wc == `MCD_MC_TXLAST;
	assign keep_sw  = is_tlc ||
		(mode_cmd && cmd_q.tx && cmd_q.wc == `MCD_MC_TXSTAT);
	assign inh_now  = chk_ok && cmd_q.tx && cmd_q.wc == `MCD_MC_INHTF;
	assign wdata_go = chk_ok && !cmd_q.tx && cmd_q.wc == `MCD_MC_SYNCD;
	assign stat_go  = !bcast_q && (ill_now || mode_cmd);

	// ****************************************
	// sequencer
	// ****************************************
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			st_q <= ST_IDLE;
		end else begin
			unique case (st_q)
				ST_IDLE: if (cmd_valid_in) st_q <= ST_CHECK;
				ST_CHECK: begin
					if (wdata_go)
						st_q <= ST_WDATA;
					else if (stat_go)
						st_q <= ST_STAT;
					else
						st_q <= ST_IDLE;
				end
				ST_WDATA: begin
					if (data_valid_in)
						st_q <= bcast_q ? ST_IDLE : ST_STAT;
				end
				ST_STAT: begin
					if (tx_ready_in)
						st_q <= (xsel_q == EX_NONE) ? ST_IDLE : ST_EXTRA;
				end
				ST_EXTRA: if (tx_ready_in) st_q <= ST_IDLE;
			endcase
		end
	end

	// command capture and field pins, valid from decode on
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			cmd_q   <= '0;
			fld_q   <= '0;
			bcast_q <= 1'b0;
			cmd_a_q <= 1'b1;
		end else if (st_q == ST_IDLE && cmd_valid_in) begin
			cmd_q     <= cmd_in;
			fld_q.is_sa <= !(cmd_in.sa == `MCD_SA_MC0 ||
				cmd_in.sa == `MCD_SA_MC31);
			fld_q.val <= (cmd_in.sa == `MCD_SA_MC0 ||
				cmd_in.sa == `MCD_SA_MC31) ? cmd_in.wc : cmd_in.sa;
			bcast_q   <= broadcast_indicator_in;
			cmd_a_q   <= cmd_on_a_in;
		end
	end

	// stored words; last command is not touched by its own readback
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			last_cmd_q  <= `MCD_WORD_RST;
			sync_data_q <= `MCD_WORD_RST;
		end else begin
			if (chk && !is_tlc)
				last_cmd_q <= cmd_q;
			if (st_q == ST_WDATA && data_valid_in)
				sync_data_q <= data_word_in;
		end
	end

	// error pin held until the next command is taken
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			message_error_pin_q <= 1'b0;
			me_q   <= 1'b0;
		end else begin
			if (st_q == ST_IDLE && cmd_valid_in)
				message_error_pin_q <= 1'b0;
			else if (chk && ill_now)
				message_error_pin_q <= 1'b1;
			if (chk && !keep_sw)
				me_q <= ill_now;
		end
	end

	// terminal flag enable and alternate bus enables
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			tf_en_q <= 1'b1;
			cha_q   <= 1'b1;
			chb_q   <= 1'b1;
		end else if (chk_ok && cmd_q.tx) begin
			if (cmd_q.wc == `MCD_MC_INHTF)
				tf_en_q <= 1'b0;
			if (cmd_q.wc == `MCD_MC_OVRTF)
				tf_en_q <= 1'b1;
			if (cmd_q.wc == `MCD_MC_TXSHUT && cmd_a_q)
				chb_q <= 1'b0;
			if (cmd_q.wc == `MCD_MC_TXSHUT && !cmd_a_q)
				cha_q <= 1'b0;
			if (cmd_q.wc == `MCD_MC_OVRSHUT && cmd_a_q)
				chb_q <= 1'b1;
			if (cmd_q.wc == `MCD_MC_OVRSHUT && !cmd_a_q)
				cha_q <= 1'b1;
		end
	end

	// one-cycle requests; the host finishes these actions itself
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			sync_q   <= 1'b0;
			stest_q  <= 1'b0;
			rstreq_q <= 1'b0;
			accept_q <= 1'b0;
		end else begin
			sync_q   <= (chk_ok && cmd_q.tx && cmd_q.wc == `MCD_MC_SYNC) ||
				(st_q == ST_WDATA && data_valid_in);
			stest_q  <= chk_ok && cmd_q.tx && cmd_q.wc == `MCD_MC_STEST;
			rstreq_q <= chk_ok && cmd_q.tx && cmd_q.wc == `MCD_MC_RSTRT;
			accept_q <= chk && !ill_now && !mode_cmd;
		end
	end

	// ****************************************
	// transmit words
	// ****************************************
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			xsel_q <= EX_NONE;
		end else if (chk) begin
			if (ill_now || !mode_cmd || !cmd_q.tx)
				xsel_q <= EX_NONE;
			else if (cmd_q.wc == `MCD_MC_TXLAST)
				xsel_q <= EX_LAST;
			else if (cmd_q.wc == `MCD_MC_TXVEC)
				xsel_q <= EX_VEC;
			else if (cmd_q.wc == `MCD_MC_TXBIT)
				xsel_q <= EX_BIT;
			else
				xsel_q <= EX_NONE;
		end
	end

	// error bit must be the fresh one when loaded from decode
	assign me_src = chk ? (keep_sw ? me_q : ill_now) : me_q;
	assign status_word = {rt_addr_in, me_src, 6'h00,
		ctl_q[`MCD_CTL_BUSY], 2'h0,
		ctl_q[`MCD_CTL_TF] & tf_en_q & !inh_now};

	always_comb begin
		unique case (xsel_q)
			EX_LAST: extra_word = last_cmd_q;
			EX_VEC:  extra_word = vec_q;
			EX_BIT:  extra_word = bit_q;
			EX_NONE: extra_word = `MCD_WORD_RST;
		endcase
	end

	// load status on the way in, the extra word when status leaves
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in)
			tx_word_q <= `MCD_WORD_RST;
		else if (st_q == ST_STAT && tx_ready_in)
			tx_word_q <= extra_word;
		else if (st_q != ST_STAT && st_q != ST_EXTRA)
			tx_word_q <= status_word;
	end

	// ****************************************
	// register bus
	// ****************************************
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_q   <= hsel_in && htrans_in[1] && hready_in && hwrite_in;
			rd_q   <= hsel_in && htrans_in[1] && hready_in && !hwrite_in;
			addr_q <= haddr_in[7:0];
		end
	end

	// writable registers take the data phase word
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			ctl_q      <= `MCD_CTL_RST;
			irq_mask_q <= `MCD_MASK_RST;
			vec_q      <= `MCD_WORD_RST;
			bit_q      <= `MCD_WORD_RST;
		end else if (wr_q) begin
			if (addr_q == `MCD_A_CTRL)
				ctl_q <= hwdata_in[2:0];
			if (addr_q == `MCD_A_IRQMASK)
				irq_mask_q <= hwdata_in[4:0];
			if (addr_q == `MCD_A_VECTOR)
				vec_q <= hwdata_in[15:0];
			if (addr_q == `MCD_A_BITWORD)
				bit_q <= hwdata_in[15:0];
		end
	end

	assign status_reg = {2'h0, message_error_pin_stk[0], 2'h0, ctl_q[`MCD_CTL_BUSY],
		tf_en_q, cha_q, chb_q, cmd_a_q, fld_q};

	// unmapped offsets read as zero
	always_comb begin
		unique case (addr_q)
			`MCD_A_STATUS:   rdata = {16'h0000, status_reg};
			`MCD_A_CTRL:     rdata = {29'h0, ctl_q};
			`MCD_A_LASTCMD:  rdata = {16'h0000, last_cmd_q};
			`MCD_A_SYNCDATA: rdata = {16'h0000, sync_data_q};
			`MCD_A_VECTOR:   rdata = {16'h0000, vec_q};
			`MCD_A_BITWORD:  rdata = {16'h0000, bit_q};
			`MCD_A_IRQSTAT:  rdata = {27'h0, irq_stat};
			`MCD_A_IRQMASK:  rdata = {27'h0, irq_mask_q};
			default:         rdata = 32'h0000_0000;
		endcase
	end

	// ****************************************
	// sticky flags and interrupt
	// ****************************************
	mcd_sticky #(.W(1)) u_message_error_pin (
		.ref_clk_in (ref_clk_in),
		.rst_b_in   (rst_b_in),
		.set_in     (chk && ill_now),
		.clr_in     (rd_q && addr_q == `MCD_A_STATUS),
		.bits_out   (message_error_pin_stk)
	);

	assign irq_ev = {rstreq_q, stest_q, sync_q,
		st_q == ST_STAT && tx_ready_in, chk && ill_now};

	mcd_sticky #(.W(`MCD_IRQ_W)) u_irq (
		.ref_clk_in (ref_clk_in),
		.rst_b_in   (rst_b_in),
		.set_in     (irq_ev),
		.clr_in     (rd_q && addr_q == `MCD_A_IRQSTAT),
		.bits_out   (irq_stat)
	);

	// ****************************************
	// outputs
	// ****************************************
	assign field_value_pins_out     = fld_q.val;
	assign field_type_indicator_out = fld_q.is_sa;
	assign message_error_pin_out    = message_error_pin_q;
	assign tx_valid_out      = (st_q == ST_STAT) || (st_q == ST_EXTRA);
	assign tx_word_out       = tx_word_q;
	assign chan_a_en_out     = cha_q;
	assign chan_b_en_out     = chb_q;
	assign sync_req_out      = sync_q;
	assign self_test_req_out = stest_q;
	assign reset_req_out     = rstreq_q;
	assign msg_accept_out    = accept_q;
	assign irq_out           = |(irq_stat & irq_mask_q);
	assign hrdata_out        = rd_q ? rdata : 32'h0000_0000;
	assign hreadyout_out     = 1'b1; // zero wait states
	assign hresp_out         = 1'b0;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_b_in);

	property p_mc_field;
		(st_q == ST_IDLE && cmd_valid_in && cmd_word_in[9:5] == 5'h1f)
		|=> !field_type_indicator_out &&
		field_value_pins_out == $past(cmd_word_in[4:0]);
	endproperty
	a_mc_field: assert property (p_mc_field)
		else $error("mode indicator not shown as mode code");

	property p_sa_field;
		(st_q == ST_IDLE && cmd_valid_in && cmd_word_in[9:5] == 5'h02)
		|=> field_type_indicator_out && field_value_pins_out == 5'h02;
	endproperty
	a_sa_field: assert property (p_sa_field)
		else $error("subaddress not shown on field pins");

	property p_mirror;
		(rd_q && addr_q == `MCD_A_STATUS) |-> hrdata_out[5:0] ==
		{field_type_indicator_out, field_value_pins_out};
	endproperty
	a_mirror: assert property (p_mirror)
		else $error("status bits differ from field pins");

	property p_reserved_mc;
		(chk && cmd_q.sa == 5'h00 && !cmd_q.tx && cmd_q.wc == 5'h14
		&& !bcast_q) |=> message_error_pin_out && tx_valid_out &&
		tx_word_out[`MCD_SW_ME] ##1 message_error_pin_stk[0];
	endproperty
	a_reserved_mc: assert property (p_reserved_mc)
		else $error("reserved mode code not flagged");

	property p_undef_mc;
		(chk && mode_cmd && cmd_q.tx && cmd_q.wc == 5'h09)
		|=> message_error_pin_out;
	endproperty
	a_undef_mc: assert property (p_undef_mc)
		else $error("undefined mode code not flagged");

	property p_tlc_keep;
		(chk && is_tlc) |=> $stable(last_cmd_q);
	endproperty
	a_tlc_keep: assert property (p_tlc_keep)
		else $error("last command overwritten by readback");

	property p_inhibit;
		(inh_now && !bcast_q) |=> !tf_en_q && tx_valid_out &&
		!tx_word_out[`MCD_SW_TF];
	endproperty
	a_inhibit: assert property (p_inhibit)
		else $error("terminal flag not inhibited");

	property p_override_tf;
		(chk_ok && cmd_q.tx && cmd_q.wc == 5'h07) |=> tf_en_q;
	endproperty
	a_override_tf: assert property (p_override_tf)
		else $error("terminal flag not re-enabled");

	property p_vector;
		(st_q == ST_EXTRA && xsel_q == EX_VEC) |-> tx_word_out == vec_q;
	endproperty
	a_vector: assert property (p_vector)
		else $error("vector word not sent after status");

	property p_reset_req;
		(chk_ok && cmd_q.tx && cmd_q.wc == 5'h08) |=> reset_req_out
		##1 !reset_req_out;
	endproperty
	a_reset_req: assert property (p_reset_req)
		else $error("reset request not pulsed");

	property p_old_table;
		(chk && !ctl_q[0] && !mode_cmd && cmd_q.sa == 5'h0e)
		|=> message_error_pin_out;
	endproperty
	a_old_table: assert property (p_old_table)
		else $error("reserved subaddress accepted");

	property p_sa_status;
		(chk && !mode_cmd && sa_bad && !bcast_q)
		|=> tx_valid_out && tx_word_out[`MCD_SW_ME];
	endproperty
	a_sa_status: assert property (p_sa_status)
		else $error("no status after reserved subaddress");

	property p_shutdown;
		(chk_ok && cmd_q.tx && cmd_q.wc == 5'h04 && cmd_a_q)
		|=> !chan_b_en_out && $stable(chan_a_en_out);
	endproperty
	a_shutdown: assert property (p_shutdown)
		else $error("alternate bus not shut down");

	property p_sync_data;
		(st_q == ST_WDATA && data_valid_in)
		|=> sync_data_q == $past(data_word_in) && sync_req_out;
	endproperty
	a_sync_data: assert property (p_sync_data)
		else $error("sync data word not stored");

	c_tlc: cover property (st_q == ST_EXTRA && xsel_q == EX_LAST);
	c_sync: cover property (st_q == ST_WDATA ##1 st_q == ST_STAT);
	c_bad_sa: cover property (chk && sa_bad && !mode_cmd);
	c_irq: cover property (irq_out);

endmodule

// [design/mcd_params.svh]
// Purpose: constants of the mode code and subaddress decoder
// Assumes: 32-bit AHB-Lite register words, byte offsets below
// Notes:   included by the decoder, the subaddress table and the bench
//
// Notes on behaviour
// - two selectable subaddress illegal tables
// - reserved mode codes decoded illegal internally
// - field pins valid once command decoded
// - type pin tells mode code or subaddress
// - type pin 1 subaddress, 0 mode code
// - status bits 0-5 mirror field pins
// - reserved mode code: store, error, status
// - undefined mode codes handled as reserved
// - transmit last command keeps stored words
// - inhibit flag: store, clear, disable flag
// - override inhibit: store, clear, enable flag
// - vector and BIT: status then data
// - sync, self-test, reset: status, host acts
// - older table: listed subaddresses are illegal
// - reserved subaddress: error, status still sent
`ifndef MCD_PARAMS_SVH
`define MCD_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define MCD_A_STATUS   8'h00
`define MCD_A_CTRL     8'h04
`define MCD_A_LASTCMD  8'h08
`define MCD_A_SYNCDATA 8'h0c
`define MCD_A_VECTOR   8'h10
`define MCD_A_BITWORD  8'h14
`define MCD_A_IRQSTAT  8'h18
`define MCD_A_IRQMASK  8'h1c

// ****************************************
// control fields and reset values
// ****************************************
`define MCD_CTL_NOTICE3 0
`define MCD_CTL_TF      1
`define MCD_CTL_BUSY    2
`define MCD_CTL_RST     3'h4
`define MCD_MASK_RST    5'h00
`define MCD_WORD_RST    16'h0000

// ****************************************
// mode codes and mode indicators
// ****************************************
`define MCD_SA_MC0     5'h00
`define MCD_SA_MC31    5'h1f
`define MCD_MC_SYNC    5'h01
`define MCD_MC_TXSTAT  5'h02
`define MCD_MC_STEST   5'h03
`define MCD_MC_TXSHUT  5'h04
`define MCD_MC_OVRSHUT 5'h05
`define MCD_MC_INHTF   5'h06
`define MCD_MC_OVRTF   5'h07
`define MCD_MC_RSTRT   5'h08
`define MCD_MC_TXVEC   5'h10
`define MCD_MC_SYNCD   5'h11
`define MCD_MC_TXLAST  5'h12
`define MCD_MC_TXBIT   5'h13

// ****************************************
// subaddress tables, one bit per subaddress
// ****************************************
`define MCD_N12_BOTH 32'h0808_4928
`define MCD_N12_RX   32'h0020_8002
`define MCD_N3_BOTH  32'h0000_0100
`define MCD_N3_RX    32'h0000_0002

// ****************************************
// status word and interrupt bits
// ****************************************
`define MCD_SW_ME    10
`define MCD_SW_BUSY  3
`define MCD_SW_TF    0
`define MCD_IRQ_W    5
`define MCD_IRQ_MESSAGE_ERROR_PIN 0
`define MCD_IRQ_DONE 1
`define MCD_IRQ_SYNC 2
`define MCD_IRQ_STST 3
`define MCD_IRQ_RST  4

`endif

// [design/mcd_pkg.sv]
// Purpose: types of the mode code and subaddress decoder
// Assumes: nothing
// Notes:   constants live in mcd_params.svh
package mcd_pkg;

	// command sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CHECK,
		ST_WDATA,
		ST_STAT,
		ST_EXTRA
	} mcd_state_e;

	// word sent after the status word
	typedef enum logic [1:0] {
		EX_NONE,
		EX_LAST,
		EX_VEC,
		EX_BIT
	} mcd_extra_e;

	// serial-bus command word layout
	typedef struct packed {
		logic [4:0] rt;
		logic       tx;
		logic [4:0] sa;
		logic [4:0] wc;
	} mcd_cmd_s;

	// decoded field shown on the pins
	typedef struct packed {
		logic       is_sa;
		logic [4:0] val;
	} mcd_field_s;

endpackage

// [design/mcd_sa_table.sv]
// Purpose: subaddress illegal lookup for both table modes
// Assumes: subaddresses 0 and 31 are filtered by the caller
// Notes:   purely combinational
`timescale 1ns/100ps
`include "mcd_params.svh"
module mcd_sa_table
	import mcd_pkg::*;
(
	input  wire logic       notice3_in,
	input  wire logic       rx_in,
	input  wire logic [4:0] sa_in,
	output logic            illegal_out
);
	logic [31:0] both_m;
	logic [31:0] rx_m;

	// table select picks the reserved masks
	assign both_m = notice3_in ? `MCD_N3_BOTH : `MCD_N12_BOTH;
	assign rx_m   = notice3_in ? `MCD_N3_RX : `MCD_N12_RX;

	// receive-only entries only bite on receive commands
	assign illegal_out = both_m[sa_in] | (rx_in & rx_m[sa_in]);

endmodule

// [design/mcd_sticky.sv]
// Purpose: sticky event bits cleared by a read
// Assumes: clear is the one-cycle read data phase
// Notes:   an event in the clearing cycle is kept
`timescale 1ns/100ps
module mcd_sticky #(
	parameter int W = 1
) (
	input  wire logic         ref_clk_in,
	input  wire logic         rst_b_in,
	input  wire logic [W-1:0] set_in,
	input  wire logic         clr_in,
	output logic [W-1:0]      bits_out
);
	logic [W-1:0] bits_q;

	// set beats clear so no event is lost
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in)
			bits_q <= '0;
		else
			bits_q <= set_in | (clr_in ? '0 : bits_q);
	end

	assign bits_out = bits_q;

endmodule

// [verification/mcd_bc_model.sv]
// Purpose: bus controller stand-in issuing command and data words
// Assumes: the decoder takes a command only while idle
// Notes:   slow_in stalls encoder acceptance every other cycle
`timescale 1ns/100ps
module mcd_bc_model (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        slow_in,
	input  wire logic        tx_valid_in,
	input  wire logic [15:0] tx_word_in,
	output logic             cmd_valid_out,
	output logic [15:0]      cmd_word_out,
	output logic             data_valid_out,
	output logic [15:0]      data_word_out,
	output logic             tx_ready_out
);
	logic [15:0] words_q [$];

	// released lines show inverted words so stale values never match
	initial begin
		{cmd_valid_out, data_valid_out, tx_ready_out} = '0;
		{cmd_word_out, data_word_out} = '1;
	end

	// encoder acceptance, every other cycle when slow
	always @(posedge ref_clk_in) begin
		if (!rst_b_in)
			tx_ready_out <= 1'b0;
		else
			tx_ready_out <= slow_in ? !tx_ready_out : 1'b1;
	end

	// words taken at the edge where ready is seen high
	always @(posedge ref_clk_in) begin
		if (rst_b_in && tx_valid_in && tx_ready_out)
			words_q.push_back(tx_word_in);
	end

	// one command, then its data word for sync with data
	task send(input logic [15:0] w, input logic wd, input logic [15:0] d);
		@(posedge ref_clk_in);
		cmd_word_out <= w;
		cmd_valid_out <= 1'b1;
		@(posedge ref_clk_in);
		cmd_valid_out <= 1'b0;
		cmd_word_out <= ~w;
		if (wd) begin
			repeat (2) @(posedge ref_clk_in);
			data_word_out <= d;
			data_valid_out <= 1'b1;
			@(posedge ref_clk_in);
			data_valid_out <= 1'b0;
			data_word_out <= ~d;
		end
	endtask
endmodule

// [verification/tb.sv]
// Purpose: self-checking bench of the mode code / subaddress decoder
// Assumes: one command at a time, registers over single word transfers
// Notes:   mode codes from a row table, subaddresses swept in a loop
`timescale 1ns/100ps
`include "mcd_params.svh"
module tb
	import mcd_pkg::*;
;
	typedef struct packed {
		logic       n3;
		logic       me;
		logic [1:0] nw;
		logic       tx;
		logic [4:0] sa;
		logic [4:0] wc;
	} mcd_row_s;
	localparam int NR = 17;
	// table select, error, word count, then the command fields
	mcd_row_s rows [NR] = '{'{0,1,1,0,0,20}, '{0,0,1,1,0,2},
		'{0,1,1,0,31,21}, '{0,1,1,1,0,0}, '{0,0,1,1,0,1},
		'{0,0,1,1,31,3}, '{0,0,1,1,0,4}, '{0,0,1,1,0,5},
		'{0,0,1,1,0,6}, '{0,0,1,1,0,7}, '{0,0,1,1,0,8},
		'{0,0,2,1,0,16}, '{0,0,2,1,0,19}, '{0,1,1,1,0,9},
		'{0,0,2,1,0,18}, '{0,0,1,0,0,17}, '{0,1,1,0,31,1}};
	logic ref_clk_in, rst_b_in, cmd_valid_in, broadcast_indicator_in;
	logic cmd_on_a_in, illegal_command_input_in, data_valid_in, tx_ready_in;
	logic hsel_in, hwrite_in, hreadyout_out, hresp_out, slow, acc_seen, bm;
	logic field_type_indicator_out, message_error_pin_out, tx_valid_out;
	logic chan_a_en_out, chan_b_en_out, msg_accept_out, irq_out;
	logic me_exp, chb_exp, tf_exp;
	logic [1:0]  htrans_in;
	logic [2:0]  hsize_in;
	logic [4:0]  rt_addr_in, field_value_pins_out;
	logic [15:0] cmd_word_in, data_word_in, tx_word_out, last_exp, exp2;
	logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
	int          fail_count, samples_checked;

	mcd_decoder i_mcd_decoder (.ref_clk_in, .rst_b_in, .cmd_valid_in,
		.cmd_word_in, .broadcast_indicator_in, .cmd_on_a_in,
		.illegal_command_input_in, .data_valid_in, .data_word_in,
		.rt_addr_in, .tx_ready_in, .field_value_pins_out,
		.field_type_indicator_out, .message_error_pin_out, .tx_valid_out,
		.tx_word_out, .chan_a_en_out, .chan_b_en_out, .sync_req_out(),
		.self_test_req_out(), .reset_req_out(), .msg_accept_out, .irq_out,
		.hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in,
		.hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out);
	mcd_bc_model i_mcd_bc_model (.ref_clk_in, .rst_b_in, .slow_in(slow),
		.tx_valid_in(tx_valid_out), .tx_word_in(tx_word_out),
		.cmd_valid_out(cmd_valid_in), .cmd_word_out(cmd_word_in),
		.data_valid_out(data_valid_in), .data_word_out(data_word_in),
		.tx_ready_out(tx_ready_in));

	// accept pulse only lasts a cycle, so latch it
	always @(posedge ref_clk_in) begin
		if (msg_accept_out === 1'b1)
			acc_seen <= 1'b1;
	end

	// ****************************************
	// checking and bus helpers
	// ****************************************
	task report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task hang;
		fail_count++;
		report_and_stop();
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("Error at %0t got %h exp %h", $time, g, e);
		end
	endtask
	// bounded wait for hready; the slave never stretches but may
	task wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (hreadyout_out !== 1'b1 && n < 50);
		if (hreadyout_out !== 1'b1)
			hang();
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		{hsel_in, hwrite_in, htrans_in, haddr_in} <= {1'b1, w, 2'b10, 24'h0, a};
		wait_rdy();
		{hsel_in, htrans_in, hwdata_in} <= {1'b0, 2'b00, d};
		wait_rdy();
		rd = hrdata_out;
	endtask
	// one command through to its last word, then pins and registers
	task run_case(input mcd_row_s r, input int id);
		mcd_cmd_s c;
		logic m;
		logic [5:0] fld;
		int n;
		c = '{5'h05, r.tx, r.sa, r.wc};
		m = r.sa == 5'h00 || r.sa == 5'h1f;
		fld = m ? {1'b0, r.wc} : {1'b1, r.sa};
		bus(1, `MCD_A_CTRL, {29'h1, 1'b1, r.n3});
		i_mcd_bc_model.words_q.delete();
		acc_seen = 1'b0;
		slow <= id[0];
		i_mcd_bc_model.send(c, !r.tx && m && r.wc == 5'h11, 16'h0bad);
		n = 0;
		while (n < 200 && !(i_mcd_bc_model.words_q.size() == r.nw &&
			tx_valid_out === 1'b0 && (r.nw != 0 || acc_seen))) begin
			@(negedge ref_clk_in);
			n++;
		end
		if (n == 200)
			hang();
		if (m && r.tx && r.wc[4:1] == 4'h2)
			chb_exp = r.wc[0];
		if (m && r.tx && r.wc[4:1] == 4'h3)
			tf_exp = r.wc[0];
		if (!(m && r.tx && (r.wc == 5'h02 || r.wc == 5'h12)))
			me_exp = r.me;
		exp2 = r.wc == 5'h10 ? 16'h1234 : r.wc == 5'h13 ? 16'h5678 : last_exp;
		if (!(m && r.tx && r.wc == 5'h12))
			last_exp = c;
		chk({field_type_indicator_out, field_value_pins_out}, fld);
		chk(message_error_pin_out, r.me);
		if (r.nw != 0)
			chk(i_mcd_bc_model.words_q[0][10], me_exp);
		if (r.nw == 2)
			chk(i_mcd_bc_model.words_q[1], exp2);
		bus(0, `MCD_A_STATUS, 0);
		chk({rd[13], rd[9], rd[7], rd[5:0], chan_b_en_out},
			{r.me, tf_exp, chb_exp, fld, chb_exp});
		bus(0, `MCD_A_LASTCMD, 0);
		chk(rd[15:0], last_exp);
		if (!r.tx && m && r.wc == 5'h11) begin
			bus(0, `MCD_A_SYNCDATA, 0);
			chk(rd[15:0], 16'h0bad);
		end
		$display("case %0d done", id);
	endtask

	initial begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{rst_b_in, illegal_command_input_in, broadcast_indicator_in} = '0;
		{hsel_in, hwrite_in, htrans_in, haddr_in, hwdata_in, slow} = '0;
		{cmd_on_a_in, rt_addr_in, hsize_in} = {1'b1, 5'h05, 3'h2};
		{me_exp, chb_exp, tf_exp, last_exp, acc_seen} = {3'h3, 17'h0};
		{fail_count, samples_checked} = '0;
		repeat (3) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		@(negedge ref_clk_in);
		chk({tx_valid_out, message_error_pin_out, field_type_indicator_out,
			field_value_pins_out, chan_a_en_out, chan_b_en_out, irq_out,
			hresp_out}, 12'h00c);
		bus(0, `MCD_A_STATUS, 0);
		chk(rd & 32'h27bf, 32'h0780);
		bus(0, `MCD_A_CTRL, 0);
		chk(rd, 32'h4);
		bus(0, 8'h40, 0);
		chk(rd, 32'h0);
		bus(1, `MCD_A_VECTOR, 32'h1234);
		bus(1, `MCD_A_BITWORD, 32'h5678);
		$display("reset test done");
		for (int i = 0; i < NR; i++)
			run_case(rows[i], i);
		// both tables, both directions, every plain subaddress
		for (int t = 0; t < 4; t++)
			for (int s = 1; s < 31; s++) begin
				bm = t[1] ? (s == 8 || (!t[0] && s == 1)) :
					(32'h0808_4928 >> s) & 1 || (!t[0] && (32'h0020_8002 >> s) & 1);
				run_case('{t[1], bm, {1'b0, bm}, t[0], s[4:0], 5'h01}, s);
			end
		illegal_command_input_in <= 1'b1;
		run_case('{0, 1, 1, 1, 2, 1}, 1);
		illegal_command_input_in <= 1'b0;
		bus(0, `MCD_A_IRQSTAT, 0);
		bus(1, `MCD_A_IRQMASK, 32'h04);
		run_case('{0, 0, 1, 1, 0, 3}, 0);
		run_case('{0, 0, 1, 1, 0, 8}, 1);
		run_case('{0, 0, 1, 1, 0, 1}, 0);
		@(negedge ref_clk_in);
		chk(irq_out, 1'b1);
		bus(0, `MCD_A_IRQSTAT, 0);
		chk(rd[4:0], 5'h1e);
		@(negedge ref_clk_in);
		chk(irq_out, 1'b0);
		bus(1, `MCD_A_IRQMASK, 32'h0);
		run_case('{0, 0, 1, 1, 0, 1}, 1);
		@(negedge ref_clk_in);
		chk(irq_out, 1'b0);
		$display("interrupt test done");
		report_and_stop();
	end
endmodule
